// *** tb/bdd_host.sv ***
// Host-side model of the serial link: framing, bit clock and parity
`timescale 1ns/1ps
module bdd_host
    import bdd_pkg::*;
(
    input wire logic clk_i,
    output logic strobe_n_o,
    output logic sck_o,
    output logic sdi_o,
    input wire logic sdo_i
);
    initial begin
        strobe_n_o = 1'b1;
        sck_o = 1'b0;
        sdi_o = 1'b0;
    end

    // Address nibble, write flag, ten data bits, odd parity in bit zero
    function automatic bdd_word_t mk(input logic [3:0] a, input logic w, input logic [9:0] d);
        return {a, w, d, ~^{a, w, d}};
    endfunction

    // Short counts only for refusal cases; clock idles low between frames
    task automatic xfer(input bdd_word_t w, input int nbits, output bdd_word_t r);
        r = '0;
        @(negedge clk_i);
        strobe_n_o = 1'b0;
        repeat (8) @(negedge clk_i);
        for (int i = 0; i < nbits; i++) begin
            sdi_o = w[15 - i];
            repeat (6) @(negedge clk_i);
            r[15 - i] = sdo_i;
            sck_o = 1'b1;
            repeat (6) @(negedge clk_i);
            sck_o = 1'b0;
        end
        repeat (6) @(negedge clk_i);
        strobe_n_o = 1'b1;
        // Released data line toggles so a stale bit is never mistaken for data
        sdi_o = ~sdi_o;
        repeat (8) @(negedge clk_i);
    endtask
endmodule

// *** tb/bdd_regs_properties.sv ***
// Concurrent checks on the ports of the bridge register set
`timescale 1ns/1ps
module bdd_regs_props
    import bdd_pkg::*;
(
    input wire logic MCLK_I,
    input wire logic NRST_I,
    input wire logic STROBE_N_I,
    input wire logic SCK_I,
    input wire logic SDI_I,
    input wire logic SDO_O,
    input wire bdd_fault_s FAULT_I,
    input wire bdd_check_res_s CHECK_RES_I,
    input wire bdd_check_req_s CHECK_REQ_O,
    input wire logic CHECK_START_O,
    input wire bdd_ctrl_s CTRL_O,
    input wire logic FAULT_STOP_O
);
    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (!NRST_I);

    property p_sdo_idle;
        STROBE_N_I [*8] |-> !SDO_O;
    endproperty
    a_sdo_idle: assert property (p_sdo_idle)
        else $error("reply line not low outside frame");

    property p_rst_out;
        $rose(NRST_I) |=> CTRL_O == 6'h10 && CHECK_REQ_O == 9'h000 && !FAULT_STOP_O;
    endproperty
    a_rst_out: assert property (p_rst_out)
        else $error("outputs wrong after reset");

    property p_start_pulse;
        CHECK_START_O |=> !CHECK_START_O;
    endproperty
    a_start_pulse: assert property (p_start_pulse)
        else $error("check start longer than one cycle");

    property p_start_req;
        CHECK_START_O |-> CHECK_REQ_O[7:0] != 8'h00 && STROBE_N_I && $past(STROBE_N_I, 3);
    endproperty
    a_start_req: assert property (p_start_req)
        else $error("check start without request or inside frame");

    property p_req_frame;
        $changed(CHECK_REQ_O) |-> STROBE_N_I && $past(STROBE_N_I, 3);
    endproperty
    a_req_frame: assert property (p_req_frame)
        else $error("check request changed inside frame");

    property p_ctrl_frame;
        $changed(CTRL_O.boot_mgr_off) |-> STROBE_N_I && $past(STROBE_N_I, 3);
    endproperty
    a_ctrl_frame: assert property (p_ctrl_frame)
        else $error("control changed inside frame");

    property p_halt_gate;
        FAULT_STOP_O && $past(FAULT_STOP_O) |-> CTRL_O.gate_cmd == 4'h0 && CTRL_O.halt_on_fault;
    endproperty
    a_halt_gate: assert property (p_halt_gate)
        else $error("gate drive active while stopped");

    property p_sdo_hold;
        (!STROBE_N_I && !SCK_I) [*6] ##1 (!STROBE_N_I && SCK_I) |=> $stable(SDO_O) [*3];
    endproperty
    a_sdo_hold: assert property (p_sdo_hold)
        else $error("reply bit moved while bit clock high");
endmodule

bind bdd_regs bdd_regs_props chk_u (.MCLK_I(MCLK_I), .NRST_I(NRST_I),
    .STROBE_N_I(STROBE_N_I), .SCK_I(SCK_I), .SDI_I(SDI_I), .SDO_O(SDO_O),
    .FAULT_I(FAULT_I), .CHECK_RES_I(CHECK_RES_I), .CHECK_REQ_O(CHECK_REQ_O),
    .CHECK_START_O(CHECK_START_O), .CTRL_O(CTRL_O), .FAULT_STOP_O(FAULT_STOP_O));

// *** tb/tb_bdd_regs.sv ***
// Self-checking bench for the bridge register set
`timescale 1ns/1ps
module tb_bdd_regs;
    import bdd_pkg::*;
    logic mclk;
    logic rst_n;
    logic strobe_n;
    logic sck;
    logic sdi;
    logic sdo;
    logic check_start;
    logic fault_stop;
    bdd_fault_s fault;
    bdd_check_res_s check_res;
    bdd_check_req_s check_req;
    bdd_ctrl_s ctrl;
    bdd_word_t rep;
    int n_fail = 0;
    int samples_checked = 0;
    int starts = 0;
    int cycles = 0;
    logic [3:0] rd_addr [9] = '{4'h7, 4'h8, 4'h9, 4'ha, 4'hb, 4'hc, 4'hd, 4'he, 4'hf};

    bdd_regs dut_u (.MCLK_I(mclk), .NRST_I(rst_n), .STROBE_N_I(strobe_n), .SCK_I(sck),
        .SDI_I(sdi), .SDO_O(sdo), .FAULT_I(fault), .CHECK_RES_I(check_res),
        .CHECK_REQ_O(check_req), .CHECK_START_O(check_start), .CTRL_O(ctrl),
        .FAULT_STOP_O(fault_stop));
    bdd_host host_u (.clk_i(mclk), .strobe_n_o(strobe_n), .sck_o(sck), .sdi_o(sdi),
        .sdo_i(sdo));

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Frames are long, so the ceiling sits well above the planned traffic
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (check_start === 1'b1) begin
            starts <= starts + 1;
        end
        if (cycles == 30000) begin
            n_fail++;
            final_report();
        end
    end

    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic xfer(input bdd_word_t w, input int nbits);
        host_u.xfer(w, nbits, rep);
    endtask

    task automatic wr(input logic [3:0] a, input logic [9:0] d);
        xfer(host_u.mk(a, 1'b1, d), 16);
    endtask

    // Replies lag one frame, so the second read carries the data
    task automatic rd(input logic [3:0] a, input logic [9:0] d);
        xfer(host_u.mk(a, 1'b0, 10'h000), 16);
        xfer(host_u.mk(a, 1'b0, 10'h000), 16);
        check($sformatf("register %h", a), host_u.mk(a, 1'b0, d), rep);
    endtask

    initial begin
        rst_n = 1'b0;
        fault = '0;
        check_res = '0;
        repeat (4) @(negedge mclk);
        rst_n = 1'b1;
        repeat (4) @(negedge mclk);
        xfer(host_u.mk(4'hf, 1'b0, 10'h000), 16);
        check("status after reset", 16'hc001, rep);
        check("control port", 16'h0010, 16'(ctrl));
        foreach (rd_addr[i]) rd(rd_addr[i], (rd_addr[i] == 4'hf) ? 10'h040 : 10'h000);
        wr(4'hf, 10'h08a);
        check("control port", 16'h002a, 16'(ctrl));
        rd(4'hf, 10'h08a);
        xfer(host_u.mk(4'hf, 1'b1, 10'h000) ^ 16'h0001, 16);
        check("control port", 16'h002a, 16'(ctrl));
        xfer(host_u.mk(4'h0, 1'b0, 10'h000), 16);
        check("serial error", 16'h0001, {15'h0000, rep[13]});
        xfer(host_u.mk(4'hf, 1'b1, 10'h000), 15);
        check("control port", 16'h002a, 16'(ctrl));
        wr(4'h7, 10'h201);
        check("check request", 16'h0101, 16'(check_req));
        wr(4'h7, 10'h000);
        check("check starts", 16'h0001, 16'(starts));
        check_res = '1;
        rd(4'h8, 10'h03b);
        rd(4'h9, 10'h019);
        wr(4'ha, 10'h0cf);
        wr(4'hb, 10'h3cf);
        fault.gate_uv = 4'hf;
        fault.drain_ov = 4'hf;
        fault.reg_overvolt = 1'b1;
        rd(4'hc, 10'h000);
        rd(4'hd, 10'h000);
        wr(4'ha, 10'h000);
        wr(4'hb, 10'h000);
        rd(4'hc, 10'h00f);
        rd(4'hd, 10'h20f);
        fault.batt_overvolt = 1'b1;
        fault.boot_uv_phase_b = 1'b1;
        fault.overcurrent_phase_a = 1'b1;
        fault.load_missing_fault = 1'b1;
        rd(4'he, 10'h243);
        // Every detector raised, so each status flag except power-on and serial error must show
        fault = '1;
        xfer(host_u.mk(4'h0, 1'b0, 10'h000), 16);
        xfer(host_u.mk(4'h0, 1'b0, 10'h000), 16);
        check("status summary", host_u.mk(4'h8, 1'b1, 10'h3ef), rep);
        wr(4'hf, 10'h04a);
        check("control port", 16'h0010, 16'(ctrl));
        check("fault stop", 16'h0001, {15'h0000, fault_stop});
        fault = '0;
        repeat (20) @(negedge mclk);
        check("fault stop", 16'h0001, {15'h0000, fault_stop});
        final_report();
    end
endmodule

// *** verilog/bdd_link.sv ***
// Serial frame engine: pin synchronisers, receive and transmit shifters
`timescale 1ns/1ps
`include "bdd_params.svh"
module bdd_link
    import bdd_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic strobe_n_i,
    input wire logic sck_i,
    input wire logic sdi_i,
    input wire bdd_word_t tx_word_i,
    output logic load_o,
    output logic done_o,
    output logic len_ok_o,
    output bdd_word_t rx_word_o,
    output logic sdo_o
);
    logic [2:0] stb_sync_ff;
    logic [2:0] sck_sync_ff;
    logic [1:0] sdi_sync_ff;
    bdd_link_e state_ff;
    logic [4:0] cnt_ff;
    bdd_word_t rx_ff;
    bdd_word_t tx_ff;
    logic sck_rise;
    logic sck_fall;
    logic stb_fall;
    logic stb_rise;

    // Stage 0 is read only by stage 1; edges come from stages 1 and 2
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            stb_sync_ff <= 3'h7;
            sck_sync_ff <= 3'h0;
            sdi_sync_ff <= 2'h0;
        end else begin
            stb_sync_ff <= {stb_sync_ff[1:0], strobe_n_i};
            sck_sync_ff <= {sck_sync_ff[1:0], sck_i};
            sdi_sync_ff <= {sdi_sync_ff[0], sdi_i};
        end
    end

    assign sck_rise = sck_sync_ff[1] & ~sck_sync_ff[2];
    assign sck_fall = ~sck_sync_ff[1] & sck_sync_ff[2];
    assign stb_fall = ~stb_sync_ff[1] & stb_sync_ff[2];
    assign stb_rise = stb_sync_ff[1] & ~stb_sync_ff[2];

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state_ff <= BDD_IDLE;
            cnt_ff <= 5'h00;
            rx_ff <= 16'h0000;
            tx_ff <= 16'h0000;
            load_o <= 1'b0;
            done_o <= 1'b0;
            len_ok_o <= 1'b0;
            rx_word_o <= 16'h0000;
        end else begin
            load_o <= 1'b0;
            done_o <= 1'b0;
            unique case (state_ff)
                BDD_IDLE: begin
                    if (stb_fall) begin
                        state_ff <= BDD_SHIFT;
                        cnt_ff <= 5'h00;
                        load_o <= 1'b1;
                    end
                end
                BDD_SHIFT: begin
                    if (stb_rise) begin
                        state_ff <= BDD_IDLE;
                        done_o <= 1'b1;
                        len_ok_o <= (cnt_ff == 5'h10);
                        rx_word_o <= rx_ff;
                    end else begin
                        if (sck_rise) begin
                            rx_ff <= {rx_ff[14:0], sdi_sync_ff[1]};
                            if (cnt_ff != 5'h1f) begin
                                cnt_ff <= cnt_ff + 5'h01;
                            end
                        end
                        // Reply taken on the read-clear edge, so a fault set then is kept
                        if (load_o) begin
                            tx_ff <= tx_word_i;
                        end else if (sck_fall) begin
                            tx_ff <= {tx_ff[14:0], 1'b0};
                        end
                    end
                end
                default: state_ff <= BDD_IDLE;
            endcase
        end
    end

    // Most significant bit first; low outside a frame
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            sdo_o <= 1'b0;
        end else begin
            sdo_o <= (state_ff == BDD_SHIFT) ? tx_ff[15] : 1'b0;
        end
    end
endmodule

// *** verilog/bdd_params.svh ***
// Offsets, field positions, reset values and masks of the bridge register set
`ifndef BDD_PARAMS_SVH
`define BDD_PARAMS_SVH
`define BDD_WORD_BITS 16
`define BDD_ADDR_MSB 15
`define BDD_ADDR_LSB 12
`define BDD_WR_BIT 11
`define BDD_PAR_BIT 0
`define BDD_ADDR_CMD_B 4'h7
`define BDD_ADDR_RES_A 4'h8
`define BDD_ADDR_RES_B 4'h9
`define BDD_ADDR_MASK_A 4'ha
`define BDD_ADDR_MASK_B 4'hb
`define BDD_ADDR_FLT_A 4'hc
`define BDD_ADDR_FLT_B 4'hd
`define BDD_ADDR_FLT_C 4'he
`define BDD_ADDR_CTRL 4'hf
`define BDD_WMASK_CMD_B 16'h07de
`define BDD_WMASK_MASK_A 16'h019e
`define BDD_WMASK_MASK_B 16'h079e
`define BDD_WMASK_CTRL 16'h019e
`define BDD_RST_CMD_B 16'h0000
`define BDD_RST_MASK 16'h0000
`define BDD_RST_CTRL 16'h0080
`define BDD_RST_FLT 16'h0000
`define BDD_QUAD_MSB 4
`define BDD_QUAD_LSB 1
`define BDD_CB_PHASE 10
`define BDD_CT_BOOT_OFF 8
`define BDD_CT_HALT 7
`define BDD_MA_BOOT 8
`define BDD_MA_TW 7
`define BDD_MB_RO 10
`define BDD_MB_RU 9
`define BDD_MB_VS 8
`define BDD_MB_VLO 7
`define BDD_FB_RO 10
`define BDD_FB_RU 9
`define BDD_FC_SO 10
`define BDD_FC_SU 9
`define BDD_FC_VB 7
`define BDD_FC_VA 6
`define BDD_FC_OCB 3
`define BDD_FC_OCA 2
`define BDD_FC_OL 1
`define BDD_ST_FF 15
`define BDD_ST_POR 14
`define BDD_ST_SE 13
`define BDD_ST_OT 11
`define BDD_ST_TW 10
`define BDD_ST_VS 9
`define BDD_ST_VLO 8
`define BDD_ST_ETO 7
`define BDD_ST_VR 6
`define BDD_ST_LDF 4
`define BDD_ST_BSU 3
`define BDD_ST_GSU 2
`define BDD_ST_DSO 1
`endif

// *** verilog/bdd_pkg.sv ***
// Types shared by the bridge register set
package bdd_pkg;
    typedef logic [15:0] bdd_word_t;
    typedef enum logic [1:0] {
        BDD_IDLE = 2'b01,
        BDD_SHIFT = 2'b10
    } bdd_link_e;
    typedef struct packed {
        logic [3:0] gate_uv;
        logic [3:0] drain_ov;
        logic reg_overvolt;
        logic reg_undervolt;
        logic batt_overvolt;
        logic batt_undervolt;
        logic boot_uv_phase_b;
        logic boot_uv_phase_a;
        logic overcurrent_phase_b;
        logic overcurrent_phase_a;
        logic load_missing_fault;
        logic thermal_warning;
        logic over_temperature_flag;
        logic logic_overvolt;
        logic enable_watchdog_expired;
    } bdd_fault_s;
    typedef struct packed {
        logic phase_b_link;
        logic phase_a_link;
        logic bridge_supply_disconnect;
        logic [1:0] low_sense_disconnect;
        logic phase_b_level;
        logic phase_a_level;
        logic amp_disconnect;
    } bdd_check_res_s;
    typedef struct packed {
        logic idle_test_phase_pick;
        logic verify_hs_phase_link;
        logic verify_ls_phase_link;
        logic verify_drain_overvolt;
        logic verify_overcurrent;
        logic verify_gate_undervolt;
        logic verify_on_load_missing;
        logic verify_off_source;
        logic verify_off_sink;
    } bdd_check_req_s;
    typedef struct packed {
        logic boot_mgr_off;
        logic halt_on_fault;
        logic [3:0] gate_cmd;
    } bdd_ctrl_s;
endpackage

// *** verilog/bdd_regs.sv ***
// Diagnostic and control register set of the bridge driver, serial access
`timescale 1ns/1ps
`include "bdd_params.svh"
module bdd_regs
    import bdd_pkg::*;
(
    input wire logic MCLK_I,
    input wire logic NRST_I,
    input wire logic STROBE_N_I,
    input wire logic SCK_I,
    input wire logic SDI_I,
    output logic SDO_O,
    input wire bdd_fault_s FAULT_I,
    input wire bdd_check_res_s CHECK_RES_I,
    output bdd_check_req_s CHECK_REQ_O,
    output logic CHECK_START_O,
    output bdd_ctrl_s CTRL_O,
    output logic FAULT_STOP_O
);
    function automatic logic odd_par(input bdd_word_t w);
        odd_par = ~(^w[15:1]);
    endfunction

    function automatic bdd_word_t with_par(input bdd_word_t w);
        with_par = {w[15:1], odd_par(w)};
    endfunction

    function automatic logic is_mapped(input logic [3:0] a);
        is_mapped = (a >= `BDD_ADDR_CMD_B);
    endfunction

    bdd_fault_s flt_meta_ff;
    bdd_fault_s flt_ff;
    bdd_check_res_s res_meta_ff;
    bdd_check_res_s res_ff;
    bdd_word_t cmd_b_ff;
    bdd_word_t mask_a_ff;
    bdd_word_t mask_b_ff;
    bdd_word_t ctrl_ff;
    bdd_word_t flt_a_ff;
    bdd_word_t flt_b_ff;
    bdd_word_t flt_c_ff;
    logic por_ff;
    logic ser_err_ff;
    logic ot_ff;
    logic tw_ff;
    logic vlo_ff;
    logic eto_ff;
    logic start_ff;
    logic sel_sts_ff;
    logic [3:0] sel_addr_ff;
    bdd_word_t nxt_flt_a;
    bdd_word_t nxt_flt_b;
    bdd_word_t nxt_flt_c;
    bdd_word_t status_w;
    bdd_word_t res_a_w;
    bdd_word_t res_b_w;
    bdd_word_t rd_w;
    bdd_word_t tx_w;
    bdd_word_t rx_w;
    logic load;
    logic done;
    logic len_ok;
    logic rx_good;
    logic rx_wr;
    logic [3:0] rx_addr;
    logic clr_flt_a;
    logic clr_flt_b;
    logic clr_flt_c;
    logic clr_sts;
    logic sum_vs;
    logic sum_vr;
    logic sum_ldf;
    logic sum_bsu;
    logic sum_gsu;
    logic sum_dso;
    logic any_fault;

    bdd_link u_link (
        .clk_i(MCLK_I),
        .rst_n_i(NRST_I),
        .strobe_n_i(STROBE_N_I),
        .sck_i(SCK_I),
        .sdi_i(SDI_I),
        .tx_word_i(tx_w),
        .load_o(load),
        .done_o(done),
        .len_ok_o(len_ok),
        .rx_word_o(rx_w),
        .sdo_o(SDO_O)
    );

    // Detector lines are asynchronous to this clock
    always_ff @(posedge MCLK_I) begin
        if (!NRST_I) begin
            flt_meta_ff <= '0;
            flt_ff <= '0;
            res_meta_ff <= '0;
            res_ff <= '0;
        end else begin
            flt_meta_ff <= FAULT_I;
            flt_ff <= flt_meta_ff;
            res_meta_ff <= CHECK_RES_I;
            res_ff <= res_meta_ff;
        end
    end

    // Frame decode; a bad length or parity never writes
    assign rx_addr = rx_w[`BDD_ADDR_MSB:`BDD_ADDR_LSB];
    assign rx_wr = rx_w[`BDD_WR_BIT];
    assign rx_good = done & len_ok & (^rx_w);

    always_ff @(posedge MCLK_I) begin
        if (!NRST_I) begin
            cmd_b_ff <= `BDD_RST_CMD_B;
            start_ff <= 1'b0;
            CHECK_START_O <= 1'b0;
        end else begin
            start_ff <= 1'b0;
            // Start waits a cycle so it lands with the request bits on the port
            CHECK_START_O <= start_ff;
            if (rx_good && rx_wr && rx_addr == `BDD_ADDR_CMD_B) begin
                cmd_b_ff <= rx_w & `BDD_WMASK_CMD_B;
                // Phase pick alone starts nothing
                start_ff <= |(rx_w & `BDD_WMASK_CMD_B
                    & ~(16'h0001 << `BDD_CB_PHASE));
            end
        end
    end

    always_ff @(posedge MCLK_I) begin
        if (!NRST_I) begin
            mask_a_ff <= `BDD_RST_MASK;
            mask_b_ff <= `BDD_RST_MASK;
        end else if (rx_good && rx_wr) begin
            if (rx_addr == `BDD_ADDR_MASK_A) begin
                mask_a_ff <= rx_w & `BDD_WMASK_MASK_A;
            end
            if (rx_addr == `BDD_ADDR_MASK_B) begin
                mask_b_ff <= rx_w & `BDD_WMASK_MASK_B;
            end
        end
    end

    always_ff @(posedge MCLK_I) begin
        if (!NRST_I) begin
            ctrl_ff <= `BDD_RST_CTRL;
        end else if (rx_good && rx_wr && rx_addr == `BDD_ADDR_CTRL) begin
            ctrl_ff <= rx_w & `BDD_WMASK_CTRL;
        end
    end

    // Read clears at the start of the frame that carries the word out
    assign clr_flt_a = load & ~sel_sts_ff & (sel_addr_ff == `BDD_ADDR_FLT_A);
    assign clr_flt_b = load & ~sel_sts_ff & (sel_addr_ff == `BDD_ADDR_FLT_B);
    assign clr_flt_c = load & ~sel_sts_ff & (sel_addr_ff == `BDD_ADDR_FLT_C);
    assign clr_sts = load & sel_sts_ff;

    // Set beats clear so a fault in the read cycle is kept
    always_comb begin
        nxt_flt_a = flt_a_ff & {16{~clr_flt_a}};
        nxt_flt_b = flt_b_ff & {16{~clr_flt_b}};
        nxt_flt_c = flt_c_ff & {16{~clr_flt_c}};
        nxt_flt_a[`BDD_QUAD_MSB:`BDD_QUAD_LSB] = nxt_flt_a[`BDD_QUAD_MSB:`BDD_QUAD_LSB]
            | (flt_ff.gate_uv & ~mask_a_ff[`BDD_QUAD_MSB:`BDD_QUAD_LSB]);
        nxt_flt_b[`BDD_QUAD_MSB:`BDD_QUAD_LSB] = nxt_flt_b[`BDD_QUAD_MSB:`BDD_QUAD_LSB]
            | (flt_ff.drain_ov & ~mask_b_ff[`BDD_QUAD_MSB:`BDD_QUAD_LSB]);
        nxt_flt_b[`BDD_FB_RO] = nxt_flt_b[`BDD_FB_RO]
            | (flt_ff.reg_overvolt & ~mask_b_ff[`BDD_MB_RO]);
        nxt_flt_b[`BDD_FB_RU] = nxt_flt_b[`BDD_FB_RU]
            | (flt_ff.reg_undervolt & ~mask_b_ff[`BDD_MB_RU]);
        nxt_flt_c[`BDD_FC_SO] = nxt_flt_c[`BDD_FC_SO]
            | (flt_ff.batt_overvolt & ~mask_b_ff[`BDD_MB_VS]);
        nxt_flt_c[`BDD_FC_SU] = nxt_flt_c[`BDD_FC_SU]
            | (flt_ff.batt_undervolt & ~mask_b_ff[`BDD_MB_VS]);
        nxt_flt_c[`BDD_FC_VB] = nxt_flt_c[`BDD_FC_VB]
            | (flt_ff.boot_uv_phase_b & ~mask_a_ff[`BDD_MA_BOOT]);
        nxt_flt_c[`BDD_FC_VA] = nxt_flt_c[`BDD_FC_VA]
            | (flt_ff.boot_uv_phase_a & ~mask_a_ff[`BDD_MA_BOOT]);
        // No mask exists for overcurrent or open load
        nxt_flt_c[`BDD_FC_OCB] = nxt_flt_c[`BDD_FC_OCB] | flt_ff.overcurrent_phase_b;
        nxt_flt_c[`BDD_FC_OCA] = nxt_flt_c[`BDD_FC_OCA] | flt_ff.overcurrent_phase_a;
        nxt_flt_c[`BDD_FC_OL] = nxt_flt_c[`BDD_FC_OL] | flt_ff.load_missing_fault;
    end

    always_ff @(posedge MCLK_I) begin
        if (!NRST_I) begin
            flt_a_ff <= `BDD_RST_FLT;
            flt_b_ff <= `BDD_RST_FLT;
            flt_c_ff <= `BDD_RST_FLT;
        end else begin
            flt_a_ff <= nxt_flt_a;
            flt_b_ff <= nxt_flt_b;
            flt_c_ff <= nxt_flt_c;
        end
    end

    // Status-only flags latch; cleared by the frame that reads status
    always_ff @(posedge MCLK_I) begin
        if (!NRST_I) begin
            por_ff <= 1'b1;
            ser_err_ff <= 1'b0;
            ot_ff <= 1'b0;
            tw_ff <= 1'b0;
            vlo_ff <= 1'b0;
            eto_ff <= 1'b0;
        end else begin
            por_ff <= por_ff & ~clr_sts;
            ser_err_ff <= (ser_err_ff & ~clr_sts) | (done & ~rx_good);
            ot_ff <= (ot_ff & ~clr_sts) | flt_ff.over_temperature_flag;
            tw_ff <= (tw_ff & ~clr_sts)
                | (flt_ff.thermal_warning & ~mask_a_ff[`BDD_MA_TW]);
            vlo_ff <= (vlo_ff & ~clr_sts)
                | (flt_ff.logic_overvolt & ~mask_b_ff[`BDD_MB_VLO]);
            eto_ff <= (eto_ff & ~clr_sts) | flt_ff.enable_watchdog_expired;
        end
    end

    // Summaries follow the latched fault words directly
    assign sum_vs = flt_c_ff[`BDD_FC_SO] | flt_c_ff[`BDD_FC_SU];
    assign sum_vr = flt_b_ff[`BDD_FB_RO] | flt_b_ff[`BDD_FB_RU];
    assign sum_ldf = flt_c_ff[`BDD_FC_OCB] | flt_c_ff[`BDD_FC_OCA]
        | flt_c_ff[`BDD_FC_OL];
    assign sum_bsu = flt_c_ff[`BDD_FC_VB] | flt_c_ff[`BDD_FC_VA];
    assign sum_gsu = |flt_a_ff[`BDD_QUAD_MSB:`BDD_QUAD_LSB];
    assign sum_dso = |flt_b_ff[`BDD_QUAD_MSB:`BDD_QUAD_LSB];
    assign any_fault = ot_ff | sum_vs | sum_vr | sum_ldf | sum_bsu | sum_gsu | sum_dso
        | vlo_ff | eto_ff;

    always_comb begin
        status_w = 16'h0000;
        status_w[`BDD_ST_FF] = por_ff | ser_err_ff | tw_ff | any_fault;
        status_w[`BDD_ST_POR] = por_ff;
        status_w[`BDD_ST_SE] = ser_err_ff;
        status_w[`BDD_ST_OT] = ot_ff;
        status_w[`BDD_ST_TW] = tw_ff;
        status_w[`BDD_ST_VS] = sum_vs;
        status_w[`BDD_ST_VLO] = vlo_ff;
        status_w[`BDD_ST_ETO] = eto_ff;
        status_w[`BDD_ST_VR] = sum_vr;
        status_w[`BDD_ST_LDF] = sum_ldf;
        status_w[`BDD_ST_BSU] = sum_bsu;
        status_w[`BDD_ST_GSU] = sum_gsu;
        status_w[`BDD_ST_DSO] = sum_dso;
    end

    // Check results only mirror the detectors; nothing written sticks
    assign res_a_w = {9'h000, res_ff.phase_b_link, res_ff.phase_a_link,
        res_ff.bridge_supply_disconnect, 1'b0, res_ff.low_sense_disconnect,
        1'b0};
    assign res_b_w = {10'h000, res_ff.phase_b_level, res_ff.phase_a_level,
        2'h0, res_ff.amp_disconnect, 1'b0};

    always_comb begin
        rd_w = 16'h0000;
        unique case (sel_addr_ff)
            `BDD_ADDR_CMD_B: rd_w = cmd_b_ff;
            `BDD_ADDR_RES_A: rd_w = res_a_w;
            `BDD_ADDR_RES_B: rd_w = res_b_w;
            `BDD_ADDR_MASK_A: rd_w = mask_a_ff;
            `BDD_ADDR_MASK_B: rd_w = mask_b_ff;
            `BDD_ADDR_FLT_A: rd_w = flt_a_ff;
            `BDD_ADDR_FLT_B: rd_w = flt_b_ff;
            `BDD_ADDR_FLT_C: rd_w = flt_c_ff;
            `BDD_ADDR_CTRL: rd_w = ctrl_ff;
            default: rd_w = 16'h0000;
        endcase
        rd_w[`BDD_ADDR_MSB:`BDD_ADDR_LSB] = sel_addr_ff;
        rd_w[`BDD_WR_BIT] = 1'b0;
        tx_w = with_par(sel_sts_ff ? status_w : rd_w);
    end

    // Reply is chosen by the previous frame; writes and errors return status
    always_ff @(posedge MCLK_I) begin
        if (!NRST_I) begin
            sel_sts_ff <= 1'b1;
            sel_addr_ff <= 4'h0;
        end else if (done) begin
            sel_sts_ff <= ~rx_good | rx_wr | ~is_mapped(rx_addr);
            sel_addr_ff <= rx_addr;
        end
    end

    // Halt only when enabled; otherwise faults are just reported
    always_ff @(posedge MCLK_I) begin
        if (!NRST_I) begin
            FAULT_STOP_O <= 1'b0;
            CTRL_O <= '0;
            CHECK_REQ_O <= '0;
        end else begin
            FAULT_STOP_O <= ctrl_ff[`BDD_CT_HALT] & any_fault;
            CTRL_O.boot_mgr_off <= ctrl_ff[`BDD_CT_BOOT_OFF];
            CTRL_O.halt_on_fault <= ctrl_ff[`BDD_CT_HALT];
            CTRL_O.gate_cmd <= ctrl_ff[`BDD_QUAD_MSB:`BDD_QUAD_LSB]
                & {4{~(ctrl_ff[`BDD_CT_HALT] & any_fault)}};
            CHECK_REQ_O <= {cmd_b_ff[`BDD_CB_PHASE:6], cmd_b_ff[4:1]};
        end
    end
endmodule
